// ===== hw/swh_pkg.sv
// Package: constants and types shared by both ends of the sleep/wake link
package swh_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned LPO_DIV          = 8;      // Low-power tick divider
   localparam int unsigned SYNC_STAGES      = 2;
   localparam logic [15:0] IDLE_TIME_RESET  = 16'h0040;
   localparam logic [15:0] WAKE_TIMER_RESET = 16'h0100;

   // ==========================================================
   // Transport modes
   typedef enum logic [1:0] {
      SWH_MODE_PINS = 2'h0,
      SWH_MODE_UART = 2'h1,
      SWH_MODE_SPI  = 2'h3,
      SWH_MODE_USB  = 2'h2
   } swh_mode_e;

   // ==========================================================
   // Device power states, Gray coded in the order listed (AWAKE to SLEEP flips both bits)
   typedef enum logic [1:0] {
      SWH_OFF   = 2'h0,
      SWH_AWAKE = 2'h1,
      SWH_EVENT = 2'h3,
      SWH_SLEEP = 2'h2
   } swh_state_e;

   // Reset polarity of the wake input: low level demands wake
   localparam logic WAKE_IN_POL_RESET  = 1'b0;
   localparam logic HOST_WAKE_POL_RESET = 1'b1;

endpackage : swh_pkg

// ===== hw/swh_if.sv
// Interface: wake, flow-control and power pins between host and device
interface swh_if;
   logic device_wake_in;     // Host to device wake pin
   logic host_wake;          // Device to host wake pin
   logic uart_cts_n;         // Device drives: flow control plus device wake
   logic uart_rts_n;         // Host drives: flow control plus host wake
   logic serial_select_n;    // Host drives the serial chip select
   logic serial_attn;        // Device attention interrupt, active high
   logic usb_suspend;        // Host suspend level on the USB link
   logic usb_resume;         // Host resume pulse
   logic usb_remote_wake;    // Device remote wake-up request pulse
   logic clk_req;            // Reference clock request, polarity per variant
   logic reg_en;             // Regulator enable, active high

   modport device (
      input  device_wake_in, uart_rts_n, serial_select_n,
      input  usb_suspend, usb_resume, reg_en,
      output host_wake, uart_cts_n, serial_attn, usb_remote_wake, clk_req
   );
   modport host (
      output device_wake_in, uart_rts_n, serial_select_n,
      output usb_suspend, usb_resume, reg_en,
      input  host_wake, uart_cts_n, serial_attn, usb_remote_wake, clk_req
   );
endinterface : swh_if

// ===== hw/swh_sync.sv
// Two-stage synchroniser bank for asynchronous wake inputs
module swh_sync
   import swh_pkg::*;
#(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset_n,
   input  wire logic [WIDTH-1:0] i_async,
   input  wire logic [WIDTH-1:0] i_reset_val,
   output logic      [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } swh_sync_s;

   swh_sync_s sync_reg;
   swh_sync_s sync_next;

   // ==========================================================
   // Stage one feeds stage two only
   always_comb begin
      sync_next    = sync_reg;
      sync_next.s1 = i_async;
      sync_next.s2 = sync_reg.s1;
   end

   // Reset to zero; the consumer picks the idle level through i_reset_val
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign o_sync = sync_reg.s2 ^ i_reset_val;
endmodule // swh_sync

// ===== hw/swh_device.sv
// Device end: sleep and wake controller of the radio baseband
// Notes on behaviour
// - Separate power-downs for TX, RX, PLL, PA
// - Sleep gates clocks, keeps core state
// - Sleep timed by the LPO_DIV tick; timer or host wakes
// - Scan/sniff timer wakes, sleeps after event
// - Transports idle in sleep, wake always accepted
// - Host wake during session keeps device awake
// - Asserted wake input forces or holds awake
// - Wake input polarity configurable, resets active-low
// - Host wake output, configurable polarity
// - UART CTS carries device wake, RTS host wake
// - SPI idle select for programmed time sleeps
// - Host asserts serial select to wake
// - Attention asserted when data pending, host asleep
// - Reference clock request, active-low variant
// - Host drives active-high regulator enable
// - USB suspend/resume and remote wake-up
// - Regulator re-enable acts as full power-on
module swh_device
   import swh_pkg::*;
#(
   parameter logic CLK_REQ_ACTIVE_LOW = 1'b0,
   parameter int unsigned TIMER_W = 16
) (
   input  wire logic               i_ref_clk,
   input  wire logic               i_reset_n,
   swh_if.device                   link,
   // User side: firmware controls
   input  wire logic [1:0]         i_mode,
   input  wire logic               i_sleep_req,
   input  wire logic               i_wake_pol,
   input  wire logic               i_host_wake_pol,
   input  wire logic               i_idle_sleep_en,
   input  wire logic [TIMER_W-1:0] i_idle_time,
   input  wire logic               i_session_en,
   input  wire logic [TIMER_W-1:0] i_session_period,
   input  wire logic [TIMER_W-1:0] i_wake_time,
   input  wire logic               i_wake_time_en,
   input  wire logic               i_event_done,
   input  wire logic               i_data_pending,
   input  wire logic               i_host_asleep,
   input  wire logic               i_need_host,
   input  wire logic               i_uart_ready,
   input  wire logic               i_tx_on,
   input  wire logic               i_rx_on,
   input  wire logic               i_pll_on,
   input  wire logic               i_pa_on,
   output logic                    o_pd_tx,
   output logic                    o_pd_rx,
   output logic                    o_pd_pll,
   output logic                    o_pd_pa,
   output logic                    o_clk_gate,
   output logic                    o_core_reset,
   output logic                    o_transport_idle,
   output logic                    o_lpo_tick,
   output logic [1:0]              o_state
);
   typedef struct packed {
      swh_state_e         state;
      logic [2:0]         div;
      logic               tick;
      logic [TIMER_W-1:0] idle_cnt;
      logic [TIMER_W-1:0] sess_cnt;
      logic [TIMER_W-1:0] wake_cnt;
      logic               reg_en_d;
      logic               pd_tx;
      logic               pd_rx;
      logic               pd_pll;
      logic               pd_pa;
      logic               host_wake;
      logic               cts_n;
      logic               attn;
      logic               remote_wake;
      logic               clk_req;
   } swh_dev_s;

   swh_dev_s st_reg;
   swh_dev_s st_next;

   logic [2:0] sync_out;
   logic       wake_raw;
   logic       cs_active;
   logic       usb_susp;
   logic       host_wake_req;
   logic       usb_mode;
   logic       uart_mode;
   logic       spi_mode;
   logic       sleeping;
   logic       radio_off;

   // ==========================================================
   // Synchronise the wake pins; they enter inverted so the bank leaves
   // reset showing their idle high level and no false wake follows reset
   swh_sync #(
      .WIDTH (3)
   ) u_sync (
      .i_ref_clk   (i_ref_clk),
      .i_reset_n   (i_reset_n),
      .i_async     (~{link.device_wake_in, link.uart_rts_n,
                      link.serial_select_n}),
      .i_reset_val (3'h7),
      .o_sync      (sync_out)
   );

   assign usb_mode  = (i_mode == SWH_MODE_USB);
   assign uart_mode = (i_mode == SWH_MODE_UART);
   assign spi_mode  = (i_mode == SWH_MODE_SPI);
   assign usb_susp  = link.usb_suspend;
   assign cs_active = !sync_out[0];

   // Wake request: pin match against the programmed polarity in pin mode; RTS, select or USB suspend/resume in the others
   always_comb begin
      wake_raw = (sync_out[2] == i_wake_pol);
      if (uart_mode) begin
         wake_raw = !sync_out[1];
      end else if (spi_mode) begin
         wake_raw = cs_active;
      end else if (usb_mode) begin
         wake_raw = !usb_susp || link.usb_resume;
      end
   end

   assign host_wake_req = i_need_host || i_data_pending;
   assign sleeping      = (st_reg.state == SWH_SLEEP);
   assign radio_off     = sleeping || (st_reg.state == SWH_OFF);

   // ==========================================================
   // Next-state logic
   always_comb begin
      st_next      = st_reg;
      // Low-power tick: the only time base once the main clock is gated
      st_next.tick = 1'b0;
      st_next.div  = st_reg.div + 3'h1;
      if (st_reg.div == 3'(LPO_DIV - 1)) begin
         st_next.div  = 3'h0;
         st_next.tick = 1'b1;
      end
      st_next.reg_en_d    = link.reg_en;
      st_next.remote_wake = 1'b0;

      // Wake timers count on the slow tick only
      if (st_reg.tick) begin
         if (st_reg.sess_cnt != '0) begin
            st_next.sess_cnt = st_reg.sess_cnt - 1'b1;
         end
         if (st_reg.wake_cnt != '0) begin
            st_next.wake_cnt = st_reg.wake_cnt - 1'b1;
         end
         if (!cs_active && st_reg.idle_cnt != '0) begin
            st_next.idle_cnt = st_reg.idle_cnt - 1'b1;
         end
      end
      if (cs_active) begin
         st_next.idle_cnt = i_idle_time;
      end

      case (st_reg.state)
         SWH_OFF: begin
            if (link.reg_en) begin
               st_next.state    = SWH_AWAKE;
               st_next.idle_cnt = i_idle_time;
            end
         end
         SWH_AWAKE: begin
            if (i_session_en && st_reg.sess_cnt == '0) begin
               st_next.sess_cnt = i_session_period;
            end
            // Asserted wake always holds us up
            if (!wake_raw) begin
               if (i_sleep_req) begin
                  st_next.state    = SWH_SLEEP;
                  st_next.sess_cnt = i_session_period;
                  st_next.wake_cnt = i_wake_time;
               end else if (spi_mode && i_idle_sleep_en &&
                            st_reg.idle_cnt == '0) begin
                  st_next.state    = SWH_SLEEP;
                  st_next.sess_cnt = i_session_period;
                  st_next.wake_cnt = i_wake_time;
               end
            end
         end
         SWH_EVENT: begin
            // Host wake during a session: stay up between events
            if (wake_raw) begin
               st_next.state = SWH_AWAKE;
            end else if (i_event_done) begin
               st_next.state    = SWH_SLEEP;
               st_next.sess_cnt = i_session_period;
            end
         end
         SWH_SLEEP: begin
            // Wake accepted at any moment, before timer checks
            if (wake_raw) begin
               st_next.state    = SWH_AWAKE;
               st_next.idle_cnt = i_idle_time;
            end else if (i_wake_time_en && st_reg.wake_cnt == '0) begin
               st_next.state    = SWH_AWAKE;
               st_next.idle_cnt = i_idle_time;
            end else if (i_session_en && st_reg.sess_cnt == '0) begin
               st_next.state = SWH_EVENT;
            end
         end
         default: begin
            st_next.state = SWH_OFF;
         end
      endcase

      // Regulator drop loses everything; rising edge restarts fresh
      if (!link.reg_en) begin
         st_next.state = SWH_OFF;
      end

      // RF power-downs, forced on whenever the radio is asleep or unpowered
      st_next.pd_tx  = radio_off || !i_tx_on;
      st_next.pd_rx  = radio_off || !i_rx_on;
      st_next.pd_pll = radio_off || !i_pll_on;
      st_next.pd_pa  = radio_off || !i_pa_on;

      // Host wake output, and CTS showing the device awake and UART ready
      st_next.host_wake = (host_wake_req == i_host_wake_pol);
      st_next.cts_n = !(i_uart_ready && !radio_off);
      st_next.attn  = spi_mode && i_host_asleep && i_data_pending;
      if (usb_mode && usb_susp && host_wake_req && !st_reg.remote_wake
          && sleeping) begin
         st_next.remote_wake = 1'b1;
      end
      // Reference needed unless off or sleeping
      st_next.clk_req = !((st_next.state == SWH_SLEEP) ||
                          (st_next.state == SWH_OFF)) ^
                        CLK_REQ_ACTIVE_LOW;
   end

   // ==========================================================
   // State register
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg             <= '0;
         st_reg.state       <= SWH_OFF;
         st_reg.pd_tx       <= 1'b1;
         st_reg.pd_rx       <= 1'b1;
         st_reg.pd_pll      <= 1'b1;
         st_reg.pd_pa       <= 1'b1;
         st_reg.cts_n       <= 1'b1;
         st_reg.host_wake   <= !HOST_WAKE_POL_RESET;
         st_reg.clk_req     <= CLK_REQ_ACTIVE_LOW;
         st_reg.idle_cnt    <= TIMER_W'(IDLE_TIME_RESET);
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   assign link.host_wake       = st_reg.host_wake;
   assign link.uart_cts_n      = st_reg.cts_n;
   assign link.serial_attn     = st_reg.attn;
   assign link.usb_remote_wake = st_reg.remote_wake;
   assign link.clk_req         = st_reg.clk_req;
   assign o_pd_tx          = st_reg.pd_tx;
   assign o_pd_rx          = st_reg.pd_rx;
   assign o_pd_pll         = st_reg.pd_pll;
   assign o_pd_pa          = st_reg.pd_pa;
   assign o_clk_gate       = sleeping;
   assign o_core_reset     = (st_reg.state == SWH_OFF);
   assign o_transport_idle = sleeping;
   assign o_lpo_tick       = st_reg.tick;
   assign o_state          = st_reg.state;
endmodule // swh_device

// ===== hw/swh_host.sv
// Host end: drives wake, flow control, select and regulator pins
module swh_host
   import swh_pkg::*;
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   swh_if.host             link,
   input  wire logic       i_reg_en,
   input  wire logic       i_want_device,
   input  wire logic       i_wake_pol,
   input  wire logic       i_host_wake_pol,
   input  wire logic       i_rx_ready,
   input  wire logic       i_spi_xfer,
   input  wire logic       i_suspend,
   input  wire logic       i_resume,
   output logic            o_host_wake,
   output logic            o_cts_wake,
   output logic            o_attn,
   output logic            o_remote_wake,
   output logic            o_clk_req
);
   typedef struct packed {
      logic reg_en;
      logic wake;
      logic rts_n;
      logic cs_n;
      logic susp;
      logic resume;
      logic hw;
      logic cts;
      logic attn;
      logic rw;
      logic cr;
   } swh_host_s;

   swh_host_s h_reg;
   swh_host_s h_next;

   // ==========================================================
   // Pin drive; the regulator enable is active high
   always_comb begin
      h_next        = h_reg;
      h_next.reg_en = i_reg_en;
      h_next.wake   = i_want_device ? i_wake_pol : !i_wake_pol;
      h_next.rts_n  = !(i_rx_ready || i_want_device);
      h_next.cs_n   = !(i_spi_xfer || i_want_device);
      h_next.susp   = i_suspend;
      h_next.resume = i_resume;
      h_next.hw     = (link.host_wake == i_host_wake_pol);
      h_next.cts    = !link.uart_cts_n;
      h_next.attn   = link.serial_attn;
      h_next.rw     = link.usb_remote_wake;
      h_next.cr     = link.clk_req;
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         h_reg       <= '0;
         h_reg.wake  <= !WAKE_IN_POL_RESET;
         h_reg.rts_n <= 1'b1;
         h_reg.cs_n  <= 1'b1;
      end else begin
         h_reg <= h_next;
      end
   end

   assign link.reg_en          = h_reg.reg_en;
   assign link.device_wake_in  = h_reg.wake;
   assign link.uart_rts_n      = h_reg.rts_n;
   assign link.serial_select_n = h_reg.cs_n;
   assign link.usb_suspend     = h_reg.susp;
   assign link.usb_resume      = h_reg.resume;
   assign o_host_wake   = h_reg.hw;
   assign o_cts_wake    = h_reg.cts;
   assign o_attn        = h_reg.attn;
   assign o_remote_wake = h_reg.rw;
   assign o_clk_req     = h_reg.cr;
endmodule // swh_host

// ===== testbench/swh_checker.sv
// Checker: timing properties on the pins joining host and device
module swh_checker (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic device_wake_in,
   input wire logic host_wake,
   input wire logic uart_cts_n,
   input wire logic uart_rts_n,
   input wire logic serial_select_n,
   input wire logic serial_attn,
   input wire logic usb_suspend,
   input wire logic usb_remote_wake,
   input wire logic clk_req,
   input wire logic reg_en
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Properties, all on the one reference clock
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_reset_n);

   // Both ends leave reset with every pin deasserted, USB suspend and resume unchecked
   a_dev_reset_idle: assert property ($rose(i_reset_n) |-> uart_cts_n
      && !host_wake && !serial_attn && !usb_remote_wake && !clk_req)
      else $error("device pins not idle after reset");
   a_host_reset_idle: assert property ($rose(i_reset_n) |-> !reg_en
      && device_wake_in && uart_rts_n && serial_select_n)
      else $error("host pins not idle after reset");

   // Regulator off means a powered-down, silent device
   a_off_no_clk: assert property (!reg_en [*3] |-> !clk_req)
      else $error("clock request while regulators off");
   a_off_not_ready: assert property (!reg_en [*3] |->
      uart_cts_n && !usb_remote_wake)
      else $error("device claims ready while regulators off");

   // Clock request only follows an enabled regulator
   a_clk_req_cause: assert property (clk_req |-> $past(reg_en))
      else $error("clock request without regulator enable");
   a_power_up_clk: assert property ($rose(reg_en) |-> ##[1:3] clk_req)
      else $error("no clock request after power up");

   // Remote wake is a lone pulse and needs a suspended link first
   a_remote_pulse: assert property (usb_remote_wake |=>
      !usb_remote_wake)
      else $error("remote wake longer than one cycle");
   a_remote_cause: assert property (usb_remote_wake |->
      $past(usb_suspend, 2) || $past(usb_suspend, 3) || $past(usb_suspend, 4))
      else $error("remote wake without suspend");
endmodule // swh_checker

// ===== testbench/sleep_wake_handshake_control_tb_top.sv
// Testbench: host and device ends joined through the link interface
module sleep_wake_handshake_control_tb_top
   import swh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Stimulus and observation signals
   logic        ref_clk = 1'b0, reset_n = 1'b0;
   logic [1:0]  mode = 2'h0, last_state = 2'h0;
   logic [15:0] idle_time = 16'h0004, sess_per = 16'h0004;
   logic [15:0] wake_time = 16'h0004;
   logic [3:0]  pwr = 4'hF;
   logic        sleep_req = 1'b0, wake_pol = 1'b0, hw_pol = 1'b1;
   logic        idle_en = 1'b0, sess_en = 1'b0, wt_en = 1'b0;
   logic        ev_done = 1'b0, data_pend = 1'b0, host_asleep = 1'b0;
   logic        need_host = 1'b0, uart_rdy = 1'b1, reg_en = 1'b0;
   logic        want = 1'b1, rx_rdy = 1'b0, spi_xfer = 1'b0;
   logic        suspend = 1'b0, resume = 1'b0;
   wire [3:0]   pd;
   wire [1:0]   dev_state;
   wire         clk_gate, core_rst, tr_idle, h_wake, cts_wake, attn;
   wire         rwake, h_clk, lpo_tick;
   int          miscompares = 0, checked = 0;
   logic [1:0]  exp_q[$];

   // 25 MHz reference clock
   always #20 ref_clk = ~ref_clk;

   swh_if swh_if_i ();
   swh_device swh_device_i (
      .i_ref_clk(ref_clk), .i_reset_n(reset_n), .link(swh_if_i.device),
      .i_mode(mode), .i_sleep_req(sleep_req), .i_wake_pol(wake_pol),
      .i_host_wake_pol(hw_pol), .i_idle_sleep_en(idle_en),
      .i_idle_time(idle_time), .i_session_en(sess_en),
      .i_session_period(sess_per), .i_wake_time(wake_time),
      .i_wake_time_en(wt_en), .i_event_done(ev_done),
      .i_data_pending(data_pend), .i_host_asleep(host_asleep),
      .i_need_host(need_host), .i_uart_ready(uart_rdy),
      .i_tx_on(pwr[3]), .i_rx_on(pwr[2]), .i_pll_on(pwr[1]),
      .i_pa_on(pwr[0]), .o_pd_tx(pd[3]), .o_pd_rx(pd[2]),
      .o_pd_pll(pd[1]), .o_pd_pa(pd[0]), .o_clk_gate(clk_gate),
      .o_core_reset(core_rst), .o_transport_idle(tr_idle),
      .o_lpo_tick(lpo_tick), .o_state(dev_state));
   swh_host swh_host_i (
      .i_ref_clk(ref_clk), .i_reset_n(reset_n), .link(swh_if_i.host),
      .i_reg_en(reg_en), .i_want_device(want), .i_wake_pol(wake_pol),
      .i_host_wake_pol(hw_pol), .i_rx_ready(rx_rdy),
      .i_spi_xfer(spi_xfer), .i_suspend(suspend), .i_resume(resume),
      .o_host_wake(h_wake), .o_cts_wake(cts_wake), .o_attn(attn),
      .o_remote_wake(rwake), .o_clk_req(h_clk));
   swh_checker swh_checker_i (
      .i_ref_clk(ref_clk), .i_reset_n(reset_n),
      .device_wake_in(swh_if_i.device_wake_in),
      .host_wake(swh_if_i.host_wake), .uart_cts_n(swh_if_i.uart_cts_n),
      .uart_rts_n(swh_if_i.uart_rts_n),
      .serial_select_n(swh_if_i.serial_select_n),
      .serial_attn(swh_if_i.serial_attn),
      .usb_suspend(swh_if_i.usb_suspend),
      .usb_remote_wake(swh_if_i.usb_remote_wake),
      .clk_req(swh_if_i.clk_req), .reg_en(swh_if_i.reg_en));

   // ==========================================================
   // Reporting, comparison and waiting helpers
   task automatic flag(input string msg);
      miscompares++;
      $display("Error at %0t: %s", $time, msg);
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) flag("value differs from expectation");
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Notes the state expected next, then waits for it with a bound
   task automatic go(input logic [1:0] s, input int lim);
      int n;
      exp_q.push_back(s);
      for (n = 0; n < lim && dev_state !== s; n++) @(negedge ref_clk);
      if (dev_state !== s) flag("state wait ran out");
   endtask

   // Monitor: each state change takes the oldest note off the queue
   always @(negedge ref_clk) begin
      if (reset_n && dev_state !== last_state) begin
         last_state = dev_state;
         if (exp_q.size() == 0) begin
            flag("unexpected state change");
         end else begin
            chk({2'h0, dev_state}, {2'h0, exp_q.pop_front()});
         end
      end
   end

   // Watchdog: the whole sequence needs well under 20000 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      flag("watchdog expired");
      tally_and_finish();
   end

   // ==========================================================
   // Main sequence; the device moves only through noted states
   initial begin
      int n;
      logic [3:0] r;
      void'($urandom(32'h23FB));
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      reg_en <= 1'b1;
      go(SWH_AWAKE, 20);
      // Slow tick: exactly one pulse in every LPO_DIV clocks
      n = 0;
      repeat (4 * LPO_DIV) begin
         @(negedge ref_clk);
         n += int'(lpo_tick);
      end
      chk(4'(n), 4'h4);
      // Pin wake in both polarities, starting from active low
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         wake_pol <= i[0];
         want <= 1'b0;
         sleep_req <= 1'b1;
         go(SWH_SLEEP, 20);
         repeat (3) @(negedge ref_clk);
         chk({clk_gate, tr_idle, h_clk, 1'b0}, 4'hC);
         chk(pd, 4'hF);
         @(posedge ref_clk);
         sleep_req <= 1'b0;
         want <= 1'b1;
         go(SWH_AWAKE, 20);
         repeat (3) @(negedge ref_clk);
         chk({3'h0, h_clk}, 4'h1);
      end
      // Timer wake, then one session event back into sleep
      @(posedge ref_clk);
      want <= 1'b0;
      sleep_req <= 1'b1;
      wt_en <= 1'b1;
      go(SWH_SLEEP, 20);
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      go(SWH_AWAKE, 200);
      @(posedge ref_clk);
      wt_en <= 1'b0;
      sleep_req <= 1'b1;
      go(SWH_SLEEP, 20);
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      sess_en <= 1'b1;
      go(SWH_EVENT, 200);
      @(posedge ref_clk);
      sess_en <= 1'b0;
      ev_done <= 1'b1;
      go(SWH_SLEEP, 20);
      @(posedge ref_clk);
      ev_done <= 1'b0;
      want <= 1'b1;
      go(SWH_AWAKE, 20);
      // Held wake keeps it up with sessions enabled despite sleep requests
      @(posedge ref_clk);
      sess_en <= 1'b1;
      sleep_req <= 1'b1;
      repeat (300) @(posedge ref_clk);
      sleep_req <= 1'b0;
      sess_en <= 1'b0;
      @(negedge ref_clk);
      chk({2'h0, dev_state}, {2'h0, SWH_AWAKE});
      // Radio power-downs follow the four enables while awake
      for (int i = 0; i < 4; i++) begin
         r = 4'($urandom);
         @(posedge ref_clk);
         pwr <= r;
         repeat (3) @(negedge ref_clk);
         chk(pd, ~r);
      end
      // UART: flow-control lines carry both wakes
      @(posedge ref_clk);
      mode <= SWH_MODE_UART;
      want <= 1'b0;
      sleep_req <= 1'b1;
      go(SWH_SLEEP, 20);
      repeat (3) @(negedge ref_clk);
      chk({3'h0, cts_wake}, 4'h0);
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      rx_rdy <= 1'b1;
      want <= 1'b1;
      go(SWH_AWAKE, 20);
      repeat (3) @(negedge ref_clk);
      chk({3'h0, cts_wake}, 4'h1);
      // SPI: idle select sleeps, select wakes, pending data raises attention
      @(posedge ref_clk);
      mode <= SWH_MODE_SPI;
      want <= 1'b0;
      rx_rdy <= 1'b0;
      idle_en <= 1'b1;
      go(SWH_SLEEP, 700);
      @(posedge ref_clk);
      spi_xfer <= 1'b1;
      go(SWH_AWAKE, 20);
      @(posedge ref_clk);
      data_pend <= 1'b1;
      host_asleep <= 1'b1;
      for (n = 0; n < 20 && attn !== 1'b1; n++) @(negedge ref_clk);
      chk({3'h0, attn}, 4'h1);
      // USB: suspend, remote wake with host wake, then resume
      r = 4'($urandom);
      @(posedge ref_clk);
      data_pend <= 1'b0;
      host_asleep <= 1'b0;
      idle_en <= 1'b0;
      mode <= SWH_MODE_USB;
      spi_xfer <= 1'b0;
      suspend <= 1'b1;
      sleep_req <= 1'b1;
      hw_pol <= r[0];
      go(SWH_SLEEP, 20);
      @(posedge ref_clk);
      need_host <= 1'b1;
      for (n = 0; n < 20 && rwake !== 1'b1; n++) @(negedge ref_clk);
      chk({3'h0, rwake}, 4'h1);
      chk({3'h0, swh_if_i.host_wake}, {3'h0, r[0]});
      @(posedge ref_clk);
      need_host <= 1'b0;
      sleep_req <= 1'b0;
      resume <= 1'b1;
      go(SWH_AWAKE, 20);
      @(posedge ref_clk);
      resume <= 1'b0;
      suspend <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({3'h0, h_wake}, 4'h0);
      // Regulator cycle behaves as a fresh power-on
      @(posedge ref_clk);
      reg_en <= 1'b0;
      go(SWH_OFF, 20);
      repeat (2) @(negedge ref_clk);
      chk({3'h0, core_rst}, 4'h1);
      chk(pd, 4'hF);
      @(posedge ref_clk);
      reg_en <= 1'b1;
      go(SWH_AWAKE, 20);
      tally_and_finish();
   end
endmodule // sleep_wake_handshake_control_tb_top
